// *** pkg/tch_params.svh ***
// constants of the trim command handler: address, command codes, field positions
// assumes inclusion by the top design file and the bench, no other definitions of these names
`ifndef TCH_PARAMS_SVH
`define TCH_PARAMS_SVH

// bus address of the device, arbitrary value
`define TCH_DEV_ADDR        7'h2A
`define TCH_CMD_EMU_V       8'h90
`define TCH_CMD_EMU_I       8'h87
`define TCH_TRIM_INIT       7'h00
`define TCH_STATUS_FAIL     2'h3
`define TCH_SIGN_POS        4
`define TCH_MAG_MSB         3
`define TCH_BYTE_LAST_BIT   4'h7
`define TCH_BYTE_ACK_BIT    4'h8
`define TCH_INIT_LOAD       2'h2
`define TCH_INIT_DONE       2'h3
`define TCH_CMD_BYTE        2'h1
`define TCH_DATA_BYTE       2'h2

`endif

// *** pkg/tch_pkg.sv ***
// types and shared functions of the trim command handler
// assumes the design files refer to every item as tch_pkg::name
package tch_pkg;

	typedef enum logic [3:0]
	{
		TCH_L_IDLE = 4'h1,
		TCH_L_RECV = 4'h2,
		TCH_L_SEND = 4'h4,
		TCH_L_SKIP = 4'h8
	} tch_lstate_t;

	// link state on rising serial clock
	typedef struct packed {
		tch_lstate_t st;
		logic        start_seen;
		logic [3:0]  bit_cnt;
		logic [1:0]  byte_idx;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic [7:0]  cmd;
		logic        cmd_valid;
		logic        rw;
		logic        drive;
		logic        wr_tgl;
		logic [6:0]  wr_data;
		logic        wr_ok;
		logic        err_tgl;
		logic        rd_tgl;
	} tch_pos_t;

	// link state on falling serial clock
	typedef struct packed {
		logic oe;
		logic out;
	} tch_neg_t;

	// core state on the system clock
	typedef struct packed {
		logic [1:0] init_cnt;
		logic       wr_prev;
		logic       err_prev;
		logic       rd_prev;
		logic [6:0] cur_trim;
		logic [6:0] volt_trim;
		logic       ref_neg;
		logic [3:0] ref_mag;
		logic       fail;
		logic [1:0] burn;
	} tch_core_t;

	// one when a byte breaks even parity
	function automatic logic parity_bad(input logic [7:0] b);
		return ^b;
	endfunction

endpackage

// *** hdl/tch_sync.sv ***
// two-stage level synchroniser for a bundle of quasi-static bits
// assumes each bit is a level or a toggle that holds for several destination clocks
`timescale 1ns/1ns
module tch_sync #(
	parameter int W = 1
)
(
	// destination clock
	input  wire logic         clk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tch_sync_t;

	tch_sync_t r_reg;
	tch_sync_t r_next;

	always_comb
	begin
		r_next    = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign q = r_reg.s2;

endmodule

// *** hdl/tch_top.sv ***
// trim command handler: serial slave on the link clock, trim and fail flag on clk
// assumes the serial clock and data pins come from a bus master, nvm image is static
`timescale 1ns/1ns
`include "tch_params.svh"
module tch_top
(
	// system
	input  wire logic       clk,
	input  wire logic       rst,
	// serial link
	input  wire logic       scl_clk,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// nonvolatile image
	input  wire logic       nvm_burned_once,
	input  wire logic [6:0] nvm_first_v_trim,
	input  wire logic [6:0] nvm_first_i_trim,
	input  wire logic [1:0] nvm_burn_status,
	// reference control
	output logic      [6:0] current_trim,
	output logic      [6:0] voltage_trim,
	output logic            ref_neg,
	output logic      [3:0] ref_mag,
	output logic            parity_fail
);

	tch_pkg::tch_pos_t  p_reg;
	tch_pkg::tch_pos_t  p_next;
	tch_pkg::tch_neg_t  n_reg;
	tch_pkg::tch_neg_t  n_next;
	tch_pkg::tch_core_t c_reg;
	tch_pkg::tch_core_t c_next;

	logic        start_tgl_reg;
	logic [16:0] to_link_s;
	logic [19:0] to_core_s;

	logic        fail_s;
	logic [1:0]  burn_s;
	logic [6:0]  cur_s;
	logic [6:0]  volt_s;

	logic        burned_s;
	logic [6:0]  first_v_s;
	logic [6:0]  first_i_s;
	logic [1:0]  burn_status_s;
	logic        wr_s;
	logic        err_s;
	logic        rd_s;

	// start condition: data falls while the serial clock is high
	always_ff @(negedge sda_in or posedge rst)
	begin
		if (rst)
			start_tgl_reg <= 1'b0;
		else if (scl_clk)
			start_tgl_reg <= ~start_tgl_reg;
	end

	// core state into the link domain
	tch_sync #(
		.W (17)
	) u_to_link (
		.clk (scl_clk),
		.rst (rst),
		.d   ({c_reg.fail, c_reg.burn, c_reg.cur_trim, c_reg.volt_trim}),
		.q   (to_link_s)
	);

	assign fail_s = to_link_s[16];
	assign burn_s = to_link_s[15:14];
	assign cur_s  = to_link_s[13:7];
	assign volt_s = to_link_s[6:0];

	// pins and link events into the core domain
	tch_sync #(
		.W (20)
	) u_to_core (
		.clk (clk),
		.rst (rst),
		.d   ({nvm_burned_once, nvm_first_v_trim, nvm_first_i_trim, nvm_burn_status,
			p_reg.wr_tgl, p_reg.err_tgl, p_reg.rd_tgl}),
		.q   (to_core_s)
	);

	assign burned_s      = to_core_s[19];
	assign first_v_s     = to_core_s[18:12];
	assign first_i_s     = to_core_s[11:5];
	assign burn_status_s = to_core_s[4:3];
	assign wr_s          = to_core_s[2];
	assign err_s         = to_core_s[1];
	assign rd_s          = to_core_s[0];

	// reply byte: status, value bits zero to four, parity
	function automatic logic [7:0] reply_byte(
		input logic       fail,
		input logic [1:0] burn,
		input logic [6:0] trim
	);
		logic [1:0] status;
		logic [6:0] body;
		status = fail ? `TCH_STATUS_FAIL : burn;
		body   = {status, trim[4:0]};
		return {body, tch_pkg::parity_bad({1'b0, body})};
	endfunction

	// link side, rising serial clock
	always_comb
	begin
		logic [7:0] byte_v;
		logic       rd_cmd;
		byte_v = {p_reg.sh[6:0], sda_in};
		rd_cmd = p_reg.cmd_valid
			&& (p_reg.cmd == `TCH_CMD_EMU_V || p_reg.cmd == `TCH_CMD_EMU_I);
		p_next = p_reg;
		if (start_tgl_reg != p_reg.start_seen)
		begin
			p_next.start_seen = start_tgl_reg;
			p_next.st         = tch_pkg::TCH_L_RECV;
			p_next.bit_cnt    = 4'h1;
			p_next.byte_idx   = 2'h0;
			p_next.sh         = {7'h00, sda_in};
			p_next.drive      = 1'b0;
		end
		else
		begin
			case (p_reg.st)
				tch_pkg::TCH_L_RECV:
				begin
					if (p_reg.bit_cnt == `TCH_BYTE_ACK_BIT)
					begin
						p_next.bit_cnt = 4'h0;
						p_next.drive   = 1'b0;
						if (p_reg.rw)
						begin
							p_next.st    = tch_pkg::TCH_L_SEND;
							p_next.drive = ~p_reg.tx[7];
							p_next.tx    = {p_reg.tx[6:0], 1'b0};
						end
					end
					else
					begin
						p_next.sh      = byte_v;
						p_next.bit_cnt = p_reg.bit_cnt + 4'h1;
						if (p_reg.bit_cnt == `TCH_BYTE_LAST_BIT)
						begin
							if (p_reg.byte_idx == 2'h0)
							begin
								p_next.rw = byte_v[0];
								if (byte_v[7:1] == `TCH_DEV_ADDR)
								begin
									p_next.drive    = 1'b1;
									p_next.byte_idx = `TCH_CMD_BYTE;
									if (byte_v[0])
									begin
										p_next.cmd_valid = 1'b0;
										p_next.tx = reply_byte(fail_s, burn_s,
											p_reg.cmd == `TCH_CMD_EMU_V ? volt_s : cur_s);
										if (rd_cmd)
											p_next.rd_tgl = ~p_reg.rd_tgl;
									end
								end
								else
								begin
									p_next.rw = 1'b0;
									p_next.st = tch_pkg::TCH_L_SKIP;
								end
							end
							else if (p_reg.byte_idx == `TCH_CMD_BYTE)
							begin
								p_next.cmd       = byte_v;
								p_next.cmd_valid = 1'b1;
								p_next.drive     = 1'b1;
								p_next.byte_idx  = `TCH_DATA_BYTE;
								if (tch_pkg::parity_bad(byte_v))
									p_next.err_tgl = ~p_reg.err_tgl;
							end
							else if (p_reg.byte_idx == `TCH_DATA_BYTE)
							begin
								p_next.drive    = 1'b1;
								p_next.byte_idx = 2'h3;
								if (p_reg.cmd == `TCH_CMD_EMU_I)
								begin
									p_next.wr_tgl  = ~p_reg.wr_tgl;
									p_next.wr_data = byte_v[7:1];
									p_next.wr_ok   = ~tch_pkg::parity_bad(byte_v)
										& ~tch_pkg::parity_bad(p_reg.cmd);
								end
							end
							else
								p_next.st = tch_pkg::TCH_L_SKIP;
						end
					end
				end
				tch_pkg::TCH_L_SEND:
				begin
					if (p_reg.bit_cnt == `TCH_BYTE_ACK_BIT)
					begin
						p_next.st    = tch_pkg::TCH_L_SKIP;
						p_next.drive = 1'b0;
					end
					else
					begin
						p_next.bit_cnt = p_reg.bit_cnt + 4'h1;
						if (p_reg.bit_cnt == `TCH_BYTE_LAST_BIT)
							p_next.drive = 1'b0;
						else
						begin
							p_next.drive = ~p_reg.tx[7];
							p_next.tx    = {p_reg.tx[6:0], 1'b0};
						end
					end
				end
				default:
				begin
					p_next.drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge scl_clk or posedge rst)
	begin
		if (rst)
		begin
			p_reg       <= '0;
			p_reg.st    <= tch_pkg::TCH_L_IDLE;
			p_reg.wr_ok <= 1'b0;
		end
		else
			p_reg <= p_next;
	end

	// pin drive changes only while the serial clock is low
	always_comb
	begin
		n_next     = n_reg;
		n_next.oe  = p_reg.drive;
		n_next.out = 1'b0;
	end

	always_ff @(negedge scl_clk or posedge rst)
	begin
		if (rst)
			n_reg <= '0;
		else
			n_reg <= n_next;
	end

	// core: trim register, fail flag, status
	always_comb
	begin
		logic wr_ev;
		logic err_ev;
		logic rd_ev;
		wr_ev  = wr_s ^ c_reg.wr_prev;
		err_ev = err_s ^ c_reg.err_prev;
		rd_ev  = rd_s ^ c_reg.rd_prev;
		c_next = c_reg;
		c_next.wr_prev  = wr_s;
		c_next.err_prev = err_s;
		c_next.rd_prev  = rd_s;
		if (c_reg.init_cnt != `TCH_INIT_DONE)
		begin
			c_next.init_cnt = c_reg.init_cnt + 2'h1;
			if (c_reg.init_cnt == `TCH_INIT_LOAD)
			begin
				c_next.cur_trim  = burned_s ? first_i_s : `TCH_TRIM_INIT;
				c_next.volt_trim = burned_s ? first_v_s : `TCH_TRIM_INIT;
				c_next.burn      = burn_status_s;
			end
		end
		if (rd_ev)
			c_next.fail = 1'b0;
		if (err_ev)
			c_next.fail = 1'b1;
		if (wr_ev && !c_reg.fail)
		begin
			if (!p_reg.wr_ok)
				c_next.fail = 1'b1;
			else
				c_next.cur_trim = p_reg.wr_data;
		end
		c_next.ref_neg = c_next.cur_trim[`TCH_SIGN_POS];
		c_next.ref_mag = c_next.cur_trim[`TCH_MAG_MSB:0];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			c_reg <= '0;
		else
			c_reg <= c_next;
	end

	assign sda_out      = n_reg.out;
	assign sda_oe       = n_reg.oe;
	assign current_trim = c_reg.cur_trim;
	assign voltage_trim = c_reg.volt_trim;
	assign ref_neg      = c_reg.ref_neg;
	assign ref_mag      = c_reg.ref_mag;
	assign parity_fail  = c_reg.fail;

endmodule

// *** tb/tch_assertions.sv ***
// checker of the trim command handler, bound to its top module
// assumes the nvm image only changes while reset is high
`timescale 1ns/1ns
module tch_assertions
(
	// system
	input wire logic       clk,
	input wire logic       rst,
	// link
	input wire logic       scl_clk,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	// trim
	input wire logic       nvm_burned_once,
	input wire logic [6:0] nvm_first_i_trim,
	input wire logic [6:0] current_trim,
	input wire logic       ref_neg,
	input wire logic [3:0] ref_mag,
	input wire logic       parity_fail
);
	logic [2:0] since_reg;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// edges since reset release, saturating
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			since_reg <= 3'h0;
		else if (since_reg != 3'h7)
			since_reg <= since_reg + 3'h1;
	end
	a_ref_fields: assert property ({ref_neg, ref_mag} == current_trim[4:0])
		else $error("reference fields differ from trim");
	a_init_load: assert property (since_reg == 3'h3 |->
		current_trim == (nvm_burned_once ? nvm_first_i_trim : 7'h00))
		else $error("trim not loaded at init");
	a_fail_freeze: assert property (parity_fail && $past(parity_fail) |-> $stable(current_trim))
		else $error("trim moved while fail flag set");
	a_fail_entry: assert property ($rose(parity_fail) |-> $stable(current_trim))
		else $error("trim moved on parity fault");
	a_change_clear: assert property ($changed(current_trim) |-> !$past(parity_fail))
		else $error("write taken with fail flag set");
	a_direct_change: assert property ($changed(current_trim) |=> $stable(current_trim)[*8])
		else $error("trim passed through another value");
	a_fail_sticky: assert property ($rose(parity_fail) |=> parity_fail[*8])
		else $error("fail flag not held");
	a_clear_keeps: assert property ($fell(parity_fail) |-> $stable(current_trim))
		else $error("trim moved when flag cleared");
	a_ack_low: assert property (@(negedge scl_clk) sda_oe |-> sda_out == 1'b0)
		else $error("data pin driven high");
endmodule

bind tch_top tch_assertions u_chk (.clk, .rst, .scl_clk, .sda_out, .sda_oe, .nvm_burned_once,
	.nvm_first_i_trim, .current_trim, .ref_neg, .ref_mag, .parity_fail);

// *** tb/tch_master.sv ***
// serial bus master model driving the link clock and pulling the data line
// assumes a pull-up on the data line; clock stands high between frames
`timescale 1ns/1ns
module tch_master
(
	// link
	output logic      scl_clk,
	output logic      sda_low,
	input  wire logic sda
);
	localparam int HALF = 40;
	initial
	begin
		scl_clk = 1'b1;
		sda_low = 1'b0;
	end
	// start or repeated start, clock left low
	task automatic start();
		#5 sda_low = 1'b0;
		#HALF scl_clk = 1'b1;
		#HALF sda_low = 1'b1;
		#HALF scl_clk = 1'b0;
	endtask
	task automatic stop();
		#5 sda_low = 1'b1;
		#HALF scl_clk = 1'b1;
		#HALF sda_low = 1'b0;
		#HALF;
	endtask
	// data changes only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		#5 sda_low = !b;
		#(HALF - 5) scl_clk = 1'b1;
		r = sda;
		#HALF scl_clk = 1'b0;
	endtask
	// eight bits then the acknowledge slot, released for the nack
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(last, ack);
	endtask
endmodule

// *** tb/tch_top_bench.sv ***
// self-checking bench of the trim command handler
// assumes the master model owns the link; nvm image changes only in reset
`timescale 1ns/1ns
`include "tch_params.svh"
module tch_top_bench;
	logic       clk;
	logic       rst;
	logic       scl_clk;
	logic       m_low;
	logic       sda_out;
	logic       sda_oe;
	wire        sda = !(m_low || (sda_oe && !sda_out));
	logic       nvm_burned_once;
	logic [6:0] nvm_first_v_trim;
	logic [6:0] nvm_first_i_trim;
	logic [1:0] nvm_burn_status;
	logic [6:0] current_trim;
	logic [6:0] voltage_trim;
	logic       ref_neg;
	logic [3:0] ref_mag;
	logic       parity_fail;
	logic [6:0] cur;
	logic [7:0] rx;
	logic       ack;
	int         fails;
	int         checks_done;

	tch_master u_mst (.scl_clk, .sda_low(m_low), .sda);
	tch_top u_dut (.clk, .rst, .scl_clk, .sda_in(sda), .sda_out, .sda_oe, .nvm_burned_once,
		.nvm_first_v_trim, .nvm_first_i_trim, .nvm_burn_status, .current_trim,
		.voltage_trim, .ref_neg, .ref_mag, .parity_fail);

	always #25 clk = !clk;

	function automatic logic [7:0] with_par(input logic [6:0] x);
		return {x, ^x};
	endfunction
	function automatic logic [7:0] reply(input logic [1:0] st, input logic [6:0] t);
		return {st, t[4:0], ^{st, t[4:0]}};
	endfunction

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic send(input logic [7:0] b);
		u_mst.xfer(b, 1'b1, rx, ack);
		cmp({7'h00, ack}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		u_mst.start();
		send({`TCH_DEV_ADDR, 1'b0});
		send(c);
		send(d);
		u_mst.stop();
		repeat (8) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] exp);
		u_mst.start();
		send({`TCH_DEV_ADDR, 1'b0});
		send(c);
		u_mst.start();
		send({`TCH_DEV_ADDR, 1'b1});
		u_mst.xfer(8'hFF, 1'b1, rx, ack);
		cmp(rx, exp);
		u_mst.stop();
		repeat (8) @(posedge clk);
	endtask
	task automatic do_reset(input logic burned);
		@(posedge clk) #1 rst = 1'b1;
		nvm_burned_once = burned;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		repeat (6) @(posedge clk);
	endtask

	initial
	begin
		#2000000;
		fails++;
		report_and_stop();
	end

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		fails = 0;
		checks_done = 0;
		cur = 7'($urandom(32'h942A));
		nvm_burn_status = 2'($urandom_range(2));
		nvm_first_v_trim = 7'($urandom);
		nvm_first_i_trim = 7'($urandom);
		do_reset(1'b0);
		cmp({1'b0, current_trim}, 8'h00);
		cmp({1'b0, voltage_trim}, 8'h00);
		rd(`TCH_CMD_EMU_V, reply(nvm_burn_status, 7'h00));
		for (int i = 0; i < 6; i++)
		begin
			cur = (i == 0) ? 7'h10 : (i == 1) ? 7'h0F : {2'h0, 5'($urandom)};
			wr(`TCH_CMD_EMU_I, with_par(cur));
			cmp({1'b0, current_trim}, {1'b0, cur});
			cmp({3'h0, ref_neg, ref_mag}, {3'h0, cur[4:0]});
			rd(`TCH_CMD_EMU_I, reply(nvm_burn_status, cur));
		end
		cmp({1'b0, voltage_trim}, 8'h00);
		wr(`TCH_CMD_EMU_I, with_par(7'h05) ^ 8'h01);
		cmp({7'h00, parity_fail}, 8'h01);
		cmp({1'b0, current_trim}, {1'b0, cur});
		wr(`TCH_CMD_EMU_I, with_par(7'h06));
		cmp({1'b0, current_trim}, {1'b0, cur});
		rd(`TCH_CMD_EMU_I, reply(`TCH_STATUS_FAIL, cur));
		cmp({7'h00, parity_fail}, 8'h00);
		wr(`TCH_CMD_EMU_I, with_par(7'h06));
		cur = 7'h06;
		cmp({1'b0, current_trim}, {1'b0, cur});
		wr(`TCH_CMD_EMU_I ^ 8'h01, with_par(7'h09));
		cmp({7'h00, parity_fail}, 8'h01);
		rd(`TCH_CMD_EMU_I, reply(`TCH_STATUS_FAIL, cur));
		u_mst.start();
		u_mst.xfer({`TCH_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, rx, ack);
		cmp({7'h00, ack}, 8'h01);
		u_mst.stop();
		do_reset(1'b1);
		cmp({1'b0, current_trim}, {1'b0, nvm_first_i_trim});
		cmp({1'b0, voltage_trim}, {1'b0, nvm_first_v_trim});
		rd(`TCH_CMD_EMU_V, reply(nvm_burn_status, nvm_first_v_trim));
		report_and_stop();
	end
endmodule
